//--- rtl/aad_consts.svh
// Constants for the averaging, decimation and clock-divider block
`ifndef AAD_CONSTS_SVH
`define AAD_CONSTS_SVH
// Register offsets on the plain register port
`define AAD_OFF_CTRL      4'h0
`define AAD_OFF_PERIOD    4'h1
`define AAD_OFF_STATUS    4'h2
`define AAD_OFF_MASK      4'h3
`define AAD_OFF_RESULT0   4'h4
// Control field positions
`define AAD_CTL_AVG_LO    0
`define AAD_CTL_PRD_LO    4
`define AAD_CTL_EXT_LO    8
`define AAD_CTL_DEC_LO    12
`define AAD_CTL_DECEN     14
`define AAD_CTL_OSCEN     15
`define AAD_CTL_TIMEREN   16
// Reset values
`define AAD_CTRL_RST      17'h0
`define AAD_PERIOD_RST    16'hffff
// Scaling
`define AAD_SCALE_SHIFT   7
`define AAD_NUM_PHASES    4
// Internal oscillator tick: 50 MHz core / 4 MHz truncates to 12 cycles
`define AAD_CORE_MHZ      50
`define AAD_OSC_MHZ       4
`define AAD_OSC_DIV       (`AAD_CORE_MHZ / `AAD_OSC_MHZ)
`endif

//--- rtl/aad_pkg.sv
// Types for the averaging, decimation and clock-divider block
package aad_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_SCALE, ST_STORE} aad_state_t;
endpackage

//--- rtl/aad_top.sv
// Clock dividers, per-phase averaging and decimation with data-ready interrupt
`timescale 1ns/100ps
`include "aad_consts.svh"

////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Converter tick from oscillator or divided external
// - Sequencer tick divides converter tick 1..16
// - Data-ready once per pulse period when decimation is off
// - Same held sample converted repeatedly
// - Conversions per phase equal count plus one
// - Count resets to zero, single conversion
// - Count 0..15 gives 1..16 conversions
// - Accumulate all conversions then scale
// - Scale sum times weight over 128
// - Weight table 128 down to 8
// - Decimation averages 2,4,8,16 periods
// - Results update once per decimation group
// - Data-ready rate divided by decimation factor
// - Decimation leaves sequencer timing unchanged
// - 16-bit sequencer counter sets period
module aad_top import aad_pkg::*; #(
   parameter int DATA_W = 24,
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // External clock pin, sampled
   input wire logic ext_in_clock_in,
   // Converter result stream
   input wire logic conv_valid_in,
   input wire logic [DATA_W-1:0] conv_data_in,
   output logic conv_start_out,
   output logic [1:0] conv_phase_out,
   // Register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Host interrupt and clock outputs
   output logic data_ready_out,
   output logic sequencer_clock_out,
   output logic irq_out
);
   // Sixteen results plus headroom for the decimation sum
   localparam int ACC_W = DATA_W + 4 + 8;
   ////////////////////////////////////////////////////////////////
   // All state in one record, registered once per clock

   typedef struct packed {
      logic [16:0] ctrl;
      logic [CNT_W-1:0] period_count;
      logic [1:0] status;
      logic [1:0] mask;
      logic [`AAD_NUM_PHASES-1:0][DATA_W-1:0] averaged_result;
      logic [`AAD_NUM_PHASES-1:0][ACC_W-1:0] dec_acc;
      logic [2:0] ext_sync;
      logic [3:0] ext_div_cnt;
      logic [3:0] osc_cnt;
      logic [3:0] prd_cnt;
      logic [CNT_W-1:0] seq_cnt;
      logic [4:0] dec_cnt;
      aad_state_t state;
      logic [1:0] phase;
      logic [3:0] conv_done;
      logic [ACC_W-1:0] conversion_sum;
      logic conv_start;
      logic seq_clk;
      logic data_ready;
      logic irq;
      logic [31:0] rdata;
   } aad_regs_t;

   aad_regs_t q_r, q_nxt;

   ////////////////////////////////////////////////////////////////
   // Integer weight for each averaging count
   function automatic logic [7:0] avg_weight(input logic [3:0] n);
      case (n)
         4'h0: avg_weight = 8'h80;
         4'h1: avg_weight = 8'h40;
         4'h2: avg_weight = 8'h2b;
         4'h3: avg_weight = 8'h20;
         4'h4: avg_weight = 8'h1a;
         4'h5: avg_weight = 8'h15;
         4'h6: avg_weight = 8'h12;
         4'h7: avg_weight = 8'h10;
         4'h8: avg_weight = 8'h0e;
         4'h9: avg_weight = 8'h0d;
         4'ha: avg_weight = 8'h0c;
         4'hb: avg_weight = 8'h0b;
         4'hc: avg_weight = 8'h0a;
         4'hd: avg_weight = 8'h09;
         4'he: avg_weight = 8'h09;
         default: avg_weight = 8'h08;
      endcase
   endfunction

   logic [3:0] average_count;
   logic [3:0] pulse_rate_divider;
   logic [3:0] ext_clock_divider;
   logic [1:0] dec_sel;
   logic dec_en;
   logic osc_en;
   logic timer_en;
   logic ext_rise;
   logic conv_tick;
   logic seq_tick;
   logic period_end;
   logic [4:0] dec_len;
   logic [ACC_W+7:0] scaled;
   logic [ACC_W-1:0] sum_ext;

   ////////////////////////////////////////////////////////////////
   // Control field decode
   assign average_count = q_r.ctrl[`AAD_CTL_AVG_LO +: 4];
   assign pulse_rate_divider = q_r.ctrl[`AAD_CTL_PRD_LO +: 4];
   assign ext_clock_divider = q_r.ctrl[`AAD_CTL_EXT_LO +: 4];
   assign dec_sel = q_r.ctrl[`AAD_CTL_DEC_LO +: 2];
   assign dec_en = q_r.ctrl[`AAD_CTL_DECEN];
   assign osc_en = q_r.ctrl[`AAD_CTL_OSCEN];
   assign timer_en = q_r.ctrl[`AAD_CTL_TIMEREN];
   assign dec_len = 5'h02 << dec_sel;
   // Only the second and third stages are read; the first is settling only
   assign ext_rise = q_r.ext_sync[1] & ~q_r.ext_sync[2];

   ////////////////////////////////////////////////////////////////
   always_comb begin
      q_nxt = q_r;
      q_nxt.conv_start = 1'b0;
      q_nxt.data_ready = 1'b0;
      q_nxt.rdata = 32'h00000000;
      q_nxt.ext_sync = {q_r.ext_sync[1:0], ext_in_clock_in};
      conv_tick = 1'b0;
      seq_tick = 1'b0;
      period_end = 1'b0;
      scaled = '0;
      sum_ext = '0;

      // Converter tick source
      if (osc_en) begin
         if (q_r.osc_cnt == 4'(`AAD_OSC_DIV - 1)) begin
            q_nxt.osc_cnt = 4'h0;
            conv_tick = 1'b1;
         end else begin
            q_nxt.osc_cnt = q_r.osc_cnt + 4'h1;
         end
      end else if (ext_rise) begin
         // Ratio is host's to keep in range
         if (q_r.ext_div_cnt >= ext_clock_divider) begin
            q_nxt.ext_div_cnt = 4'h0;
            conv_tick = 1'b1;
         end else begin
            q_nxt.ext_div_cnt = q_r.ext_div_cnt + 4'h1;
         end
      end

      // Sequencer tick, divider field holds ratio minus one
      if (conv_tick) begin
         if (q_r.prd_cnt >= pulse_rate_divider) begin
            q_nxt.prd_cnt = 4'h0;
            seq_tick = 1'b1;
         end else begin
            q_nxt.prd_cnt = q_r.prd_cnt + 4'h1;
         end
      end
      // Rises at each tick, falls halfway; ratio one leaves a one-cycle high
      if (seq_tick) begin
         q_nxt.seq_clk = 1'b1;
      end else if (pulse_rate_divider == 4'h0) begin
         q_nxt.seq_clk = 1'b0;
      end else if (conv_tick && q_nxt.prd_cnt == {1'b0, pulse_rate_divider[3:1]} + 4'h1) begin
         q_nxt.seq_clk = 1'b0;
      end

      // Period counter, unaffected by decimation
      if (!timer_en) begin
         q_nxt.seq_cnt = '0;
      end else if (seq_tick) begin
         if (q_r.seq_cnt >= q_r.period_count) begin
            q_nxt.seq_cnt = '0;
            period_end = 1'b1;
         end else begin
            q_nxt.seq_cnt = q_r.seq_cnt + 1'b1;
         end
      end

      // Per-phase conversion and averaging engine
      case (q_r.state)
         ST_IDLE: begin
            if (period_end) begin
               q_nxt.state = ST_CONV;
               q_nxt.phase = 2'h0;
               q_nxt.conv_done = 4'h0;
               q_nxt.conversion_sum = '0;
               q_nxt.conv_start = 1'b1;
            end
         end
         ST_CONV: begin
            if (conv_valid_in) begin
               q_nxt.conversion_sum = q_r.conversion_sum + ACC_W'($signed(conv_data_in));
               q_nxt.conv_done = q_r.conv_done + 4'h1;
               if (q_r.conv_done == average_count) begin
                  q_nxt.state = ST_SCALE;
               end else begin
                  q_nxt.conv_start = 1'b1;
               end
            end
         end
         ST_SCALE: begin
            // Non-power-of-two counts are approximate by design
            scaled = $signed(q_r.conversion_sum) * $signed({1'b0, avg_weight(average_count)});
            sum_ext = ACC_W'($signed(scaled) >>> `AAD_SCALE_SHIFT);
            if (dec_en) begin
               q_nxt.dec_acc[q_r.phase] = q_r.dec_acc[q_r.phase] + sum_ext;
            end else begin
               q_nxt.averaged_result[q_r.phase] = DATA_W'(sum_ext);
            end
            q_nxt.state = ST_STORE;
         end
         ST_STORE: begin
            if (q_r.phase == 2'(`AAD_NUM_PHASES - 1)) begin
               q_nxt.state = ST_IDLE;
               if (!dec_en) begin
                  q_nxt.data_ready = 1'b1;
                  q_nxt.status[0] = 1'b1;
               end else if (q_r.dec_cnt + 5'h01 >= dec_len) begin
                  // Group complete: shift out factor, publish, fire
                  for (int p = 0; p < `AAD_NUM_PHASES; p++) begin
                     // Shift amount widened so a group of sixteen shifts by four
                     q_nxt.averaged_result[p] = DATA_W'($signed(q_r.dec_acc[p]) >>> ({1'b0, dec_sel} + 3'h1));
                     q_nxt.dec_acc[p] = '0;
                  end
                  q_nxt.dec_cnt = 5'h00;
                  q_nxt.data_ready = 1'b1;
                  q_nxt.status[0] = 1'b1;
               end else begin
                  q_nxt.dec_cnt = q_r.dec_cnt + 5'h01;
               end
            end else begin
               q_nxt.phase = q_r.phase + 2'h1;
               q_nxt.conv_done = 4'h0;
               q_nxt.conversion_sum = '0;
               q_nxt.conv_start = 1'b1;
               q_nxt.state = ST_CONV;
            end
         end
         default: q_nxt.state = ST_IDLE;
      endcase

      // Register port; hardware set wins over write-one clear
      if (reg_wr_in) begin
         case (reg_addr_in)
            `AAD_OFF_CTRL: q_nxt.ctrl = reg_wdata_in[16:0];
            `AAD_OFF_PERIOD: q_nxt.period_count = reg_wdata_in[CNT_W-1:0];
            `AAD_OFF_STATUS: q_nxt.status = q_nxt.status & ~(reg_wdata_in[1:0] & ~{1'b0, q_nxt.data_ready});
            `AAD_OFF_MASK: q_nxt.mask = reg_wdata_in[1:0];
            default: ;
         endcase
         // Toggling decimation restarts the group
         if (reg_addr_in == `AAD_OFF_CTRL && reg_wdata_in[`AAD_CTL_DECEN] != dec_en) begin
            q_nxt.dec_cnt = 5'h00;
            for (int p = 0; p < `AAD_NUM_PHASES; p++) q_nxt.dec_acc[p] = '0;
         end
      end
      if (period_end && q_r.state != ST_IDLE) q_nxt.status[1] = 1'b1;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `AAD_OFF_CTRL: q_nxt.rdata = {15'h0000, q_r.ctrl};
            `AAD_OFF_PERIOD: q_nxt.rdata = {{(32-CNT_W){1'b0}}, q_r.period_count};
            `AAD_OFF_STATUS: q_nxt.rdata = {30'h0, q_r.status};
            `AAD_OFF_MASK: q_nxt.rdata = {30'h0, q_r.mask};
            4'h4, 4'h5, 4'h6, 4'h7:
               q_nxt.rdata = {{(32-DATA_W){q_r.averaged_result[reg_addr_in[1:0]][DATA_W-1]}},
                              q_r.averaged_result[reg_addr_in[1:0]]};
            default: q_nxt.rdata = 32'h00000000;
         endcase
      end
      q_nxt.irq = |(q_nxt.status & q_nxt.mask);
   end

   ////////////////////////////////////////////////////////////////
   // Synchronous reset; engine and timer restart idle
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         q_r <= '0;
         q_r.ctrl <= `AAD_CTRL_RST;
         q_r.period_count <= `AAD_PERIOD_RST;
         q_r.state <= ST_IDLE;
      end else begin
         q_r <= q_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs straight from the state record
   assign conv_start_out = q_r.conv_start;
   assign conv_phase_out = q_r.phase;
   assign reg_rdata_out = q_r.rdata;
   assign data_ready_out = q_r.data_ready;
   assign sequencer_clock_out = q_r.seq_clk;
   assign irq_out = q_r.irq;
endmodule

//--- test/aad_conv_model.sv
// Converter partner: answers each start with one result
`timescale 1ns/100ps
module aad_conv_model (
   // Requests
   input wire logic clk_in,
   input wire logic start_in,
   input wire logic slow_in,
   input wire logic [31:0] rnd_in,
   // Results
   output logic valid_out = 1'b0,
   output logic [23:0] data_out = 24'h0
);
   logic busy_r = 1'b0;
   logic [3:0] wait_r = 4'h0;
   always @(posedge clk_in) begin
      valid_out <= 1'b0;
      // Stale data never looks valid
      data_out <= ~data_out;
      if (start_in) begin
         busy_r <= 1'b1;
         wait_r <= slow_in ? 4'h6 : 4'h0;
      end else if (busy_r && wait_r != 4'h0) begin
         wait_r <= wait_r - 4'h1;
      end else if (busy_r) begin
         busy_r <= 1'b0;
         valid_out <= 1'b1;
         // Kept below full scale so weighted sums never overflow
         data_out <= {{2{rnd_in[21]}}, rnd_in[21:0]};
      end
   end
endmodule

//--- test/aad_top_checker.sv
// Port-level assertions for the averaging block
`timescale 1ns/100ps
module aad_top_checker (
   // Watched ports
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic conv_valid_in,
   input wire logic conv_start_out,
   input wire logic [1:0] conv_phase_out,
   input wire logic data_ready_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (srst_in);
   a_start_pulse: assert property (conv_start_out |=> !conv_start_out) else $error("start too long");
   a_next_start: assert property (conv_valid_in && conv_phase_out != 2'h3 |-> ##[1:4] conv_start_out) else $error("no start");
   a_phase_hold: assert property (conv_valid_in |=> $stable(conv_phase_out)) else $error("phase moved");
   a_phase_step: assert property ($changed(conv_phase_out) |-> conv_phase_out == $past(conv_phase_out) + 2'h1) else $error("phase skip");
   a_ready_gap: assert property (data_ready_out |=> !data_ready_out [*8]) else $error("ready too often");
   a_ready_phase: assert property (data_ready_out |-> conv_phase_out == 2'h3) else $error("ready mid period");
   a_ready_quiet: assert property (data_ready_out |-> !conv_start_out && !$past(conv_start_out)) else $error("ready busy");
   a_ready_late: assert property (data_ready_out |-> $past(conv_valid_in, 2) || $past(conv_valid_in, 3) || $past(conv_valid_in, 4)) else $error("ready timing");
endmodule
bind aad_top aad_top_checker chk_u (.core_clk_in, .srst_in, .conv_valid_in, .conv_start_out, .conv_phase_out, .data_ready_out);

//--- test/tb_adc_average_decimate_clocking.sv
// Self-checking bench for the averaging block
`timescale 1ns/100ps
module tb_adc_average_decimate_clocking;
   localparam int PC = 63;
   logic core_clk_in = 1'b0, srst_in = 1'b1, ext_in_clock_in = 1'b0;
   logic conv_valid_in, conv_start_out, data_ready_out, irq_out, sequencer_clock_out;
   logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic [23:0] conv_data_in;
   logic [1:0] conv_phase_out;
   logic [3:0] reg_addr_in = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, v, seed = 32'h029191d4;
   int n_errors = 0, checks = 0, cyc = 0, n_dr = 0, q, n_ps = 0, ps_last = 0, ps_gap = 0, ps_dr = 0, dr_per = 0;
   int n_rise = 0, rise_per = 0, seq_prev = 0;
   int avg = 0, dec_n = 1, dec_sh = 0, pcnt = 0, grp = 0, nst[4], nval[4];
   int wt[16] = '{128, 64, 43, 32, 26, 21, 18, 16, 14, 13, 12, 11, 10, 9, 9, 8};
   longint acc[4], dsum[4], expv[4];
   aad_top dut_u (.core_clk_in, .srst_in, .ext_in_clock_in, .conv_valid_in, .conv_data_in, .conv_start_out,
      .conv_phase_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .data_ready_out,
      .sequencer_clock_out, .irq_out);
   aad_conv_model conv_u (.clk_in(core_clk_in), .start_in(conv_start_out), .slow_in(seed[31] & seed[30]),
      .rnd_in(seed), .valid_out(conv_valid_in), .data_out(conv_data_in));
   initial forever #10 core_clk_in = ~core_clk_in;
   initial #7 forever #80 ext_in_clock_in = ~ext_in_clock_in;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   always @(posedge core_clk_in) seed <= xs(seed);
   ////////////////////////////////////////////////////////////////
   task chk(input bit ok, input string msg);
      checks++;
      if (!ok) begin
         n_errors++;
         $display("Error %0t: %s", $time, msg);
      end
   endtask
   task summarize;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
      // One idle edge so a following call never re-raises in the same step
      @(posedge core_clk_in);
   endtask
   task rd(input logic [3:0] a, output logic [31:0] d);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      @(posedge core_clk_in);
      d = reg_rdata_out;
   endtask
   ////////////////////////////////////////////////////////////////
   // Reference: sums per phase, weighted scale, then group average
   always @(posedge core_clk_in) begin
      cyc++;
      // Period start: first phase-0 start; conversion latency does not move it
      if (conv_start_out && conv_phase_out == 2'h0 && nst[0] == 0) begin
         ps_gap = cyc - ps_last;
         ps_last = cyc;
         n_ps++;
         rise_per = n_rise;
         n_rise = 0;
      end
      if (sequencer_clock_out && !seq_prev) n_rise++;
      seq_prev = sequencer_clock_out;
      if (conv_start_out) nst[conv_phase_out]++;
      if (conv_valid_in) begin
         acc[conv_phase_out] += $signed(conv_data_in);
         nval[conv_phase_out]++;
      end
      if (conv_valid_in && conv_phase_out == 2'h3 && nval[3] == avg + 1) begin
         for (q = 0; q < 4; q++) begin
            chk(nst[q] == avg + 1 && nval[q] == avg + 1, "conversions per phase");
            dsum[q] += (acc[q] * wt[avg]) >>> 7;
            acc[q] = 0;
            nst[q] = 0;
            nval[q] = 0;
         end
         pcnt++;
      end
      if (pcnt == dec_n) begin
         for (q = 0; q < 4; q++) begin
            expv[q] = dsum[q] >>> dec_sh;
            dsum[q] = 0;
         end
         pcnt = 0;
         grp = 1;
      end
      if (data_ready_out) begin
         chk(grp == 1, "data ready without full group");
         grp = 0;
         dr_per = n_ps - ps_dr;
         ps_dr = n_ps;
         n_dr++;
      end
   end
   // Tick is core cycles per sequencer tick for this setting
   task automatic run(input logic [31:0] cfg, input int tick);
      int k, p;
      wr(4'h0, 32'h0);
      wr(4'h1, 32'(PC));
      avg = int'(cfg[3:0]);
      dec_n = cfg[14] ? 2 << cfg[13:12] : 1;
      dec_sh = cfg[14] ? int'(cfg[13:12]) + 1 : 0;
      pcnt = 0;
      wr(4'h0, cfg | 32'h10000);
      for (k = 0; k < 2; k++) begin
         p = n_dr;
         while (p == n_dr) @(posedge core_clk_in);
         for (p = 0; p < 4; p++) begin
            rd(4'(4 + p), v);
            chk(v === 32'(expv[p]), "averaged result");
         end
      end
      chk(ps_gap == (PC + 1) * tick, "period spacing");
      chk(rise_per == PC + 1, "sequencer clock edges");
      chk(dr_per == dec_n, "data ready per group");
   endtask
   initial begin
      int k;
      repeat (12) @(posedge core_clk_in);
      srst_in <= 1'b0;
      @(posedge core_clk_in);
      rd(4'h0, v);
      chk(v === 32'h0, "control reset");
      rd(4'h1, v);
      chk(v === 32'h0000ffff, "period reset");
      rd(4'h9, v);
      chk(v === 32'h0, "unmapped read");
      run(32'h8000, 12);
      wr(4'h3, 32'h1);
      repeat (3) @(posedge core_clk_in);
      chk(irq_out === 1'b1, "irq unmasked");
      wr(4'h3, 32'h0);
      repeat (3) @(posedge core_clk_in);
      chk(irq_out === 1'b0, "irq masked");
      rd(4'h2, v);
      chk(v === 32'h1, "status set");
      wr(4'h2, 32'h1);
      rd(4'h2, v);
      chk(v === 32'h0, "status cleared");
      run(32'h8002, 12);
      run(32'h800f, 12);
      run(32'h8011, 24);
      run(32'h0103, 16);
      for (k = 0; k < 4; k++) run(32'hc001 | 32'(k << 12), 12);
      // Overrun: a one-tick period against sixteen conversions per phase
      wr(4'h0, 32'h0);
      avg = 15;
      dec_n = 1;
      dec_sh = 0;
      pcnt = 0;
      wr(4'h1, 32'h0);
      wr(4'h0, 32'h1800f);
      repeat (60) @(posedge core_clk_in);
      rd(4'h2, v);
      chk(v[1] === 1'b1, "overrun flag");
      summarize;
   end
   initial begin
      repeat (90000) @(posedge core_clk_in);
      n_errors++;
      $display("Error %0t: timeout", $time);
      summarize;
   end
endmodule
